/* include/stu_pkg.sv */
// Purpose: shared constants and carrier types of the stencil test unit
// Assumes: 32-bit APB register bus, 8-bit stencil planes at most
// Notes:   register offsets are byte addresses, one aligned word each
package stu_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int STU_DW = 32;
   localparam int STU_AW = 8;
   localparam int STU_PW = 8;
   localparam int STU_CW = 16;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [STU_AW-1:0] STU_OFF_MODE = 8'h00;
   localparam logic [STU_AW-1:0] STU_OFF_DATA = 8'h04;
   localparam logic [STU_AW-1:0] STU_OFF_HOST = 8'h08;
   localparam logic [STU_AW-1:0] STU_OFF_WIN  = 8'h0C;
   localparam logic [STU_AW-1:0] STU_OFF_STAT = 8'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int STU_MODE_EN_POS     = 0;
   localparam int STU_MODE_DPPASS_POS = 1;
   localparam int STU_MODE_DPFAIL_POS = 4;
   localparam int STU_MODE_SFAIL_POS  = 7;
   localparam int STU_MODE_FUNC_POS   = 10;
   localparam int STU_MODE_SRC_POS    = 13;
   localparam int STU_MODE_W4_POS     = 15;
   localparam int STU_MODE_BITS       = 16;

   localparam int STU_DATA_REF_POS    = 0;
   localparam int STU_DATA_CMASK_POS  = 8;
   localparam int STU_DATA_WMASK_POS  = 16;
   localparam int STU_DATA_FCVAL_POS  = 24;

   localparam int STU_WIN_FORCE_POS   = 0;
   localparam int STU_WIN_FCEN_POS    = 1;
   localparam int STU_WIN_DEPTHEN_POS = 2;
   localparam int STU_WIN_BITS        = 3;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [STU_DW-1:0] STU_MODE_RST = 32'h0000_0000;
   localparam logic [STU_DW-1:0] STU_DATA_RST = 32'h00FF_FF00;
   localparam logic [STU_DW-1:0] STU_HOST_RST = 32'h0000_0000;
   localparam logic [STU_DW-1:0] STU_WIN_RST  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      STU_F_NEVER, STU_F_LESS, STU_F_EQUAL, STU_F_LEQUAL,
      STU_F_GREATER, STU_F_NOTEQUAL, STU_F_GEQUAL, STU_F_ALWAYS
   } stu_func_t;

   typedef enum logic [2:0] {
      STU_OP_KEEP, STU_OP_ZERO, STU_OP_REPLACE, STU_OP_INCR, STU_OP_DECR, STU_OP_INVERT
   } stu_op_t;

   typedef enum logic [1:0] {
      STU_SRC_TEST, STU_SRC_HOST, STU_SRC_COPY, STU_SRC_DEST
   } stu_src_t;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [STU_AW-1:0] paddr;
      logic [STU_DW-1:0] pwdata;
   } stu_apb_req_t;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [STU_DW-1:0] prdata;
   } stu_apb_rsp_t;

   typedef struct packed {
      logic              valid;
      logic              prior_ok;
      logic              depth_pass;
      logic              fc_pixel;
      logic [STU_PW-1:0] dest_val;
      logic [STU_PW-1:0] copy_val;
   } stu_frag_in_t;

   typedef struct packed {
      logic              valid;
      logic              alive;
      logic              plane_we;
      logic              force_update;
      logic [STU_PW-1:0] plane_val;
   } stu_frag_out_t;

endpackage

/* hw/stu_plane_alu.sv */
// Purpose: stencil compare and update-operation arithmetic, purely combinational
// Assumes: buffered value already holds fast-clear substitution
// Notes:   4-bit width limits saturation and buffered value to the low nibble
`timescale 1ns/100ps
module stu_plane_alu (
   // test setup
   input  stu_pkg::stu_func_t         i_func,
   input  stu_pkg::stu_op_t           i_op_dppass,
   input  stu_pkg::stu_op_t           i_op_dpfail,
   input  stu_pkg::stu_op_t           i_op_sfail,
   input  logic                       i_width4,
   input  logic [stu_pkg::STU_PW-1:0] i_ref,
   input  logic [stu_pkg::STU_PW-1:0] i_cmp_mask,
   // fragment data
   input  logic [stu_pkg::STU_PW-1:0] i_buf,
   input  logic                       i_depth_pass,
   // results
   output logic                       o_pass,
   output logic [stu_pkg::STU_PW-1:0] o_result
);
   import stu_pkg::*;

   logic [STU_PW-1:0] m_ref;
   logic [STU_PW-1:0] m_buf;
   logic [STU_PW-1:0] lim;
   logic [STU_PW-1:0] buf_l;
   stu_op_t           op;

   always_comb begin
      m_ref = i_ref & i_cmp_mask;
      m_buf = i_buf & i_cmp_mask;
      lim   = i_width4 ? 8'h0F : 8'hFF;
      buf_l = i_buf & lim;
      // reference sits on the left: less means reference below buffer
      case (i_func)
         STU_F_NEVER:    o_pass = 1'b0;
         STU_F_LESS:     o_pass = m_ref <  m_buf;
         STU_F_EQUAL:    o_pass = m_ref == m_buf;
         STU_F_LEQUAL:   o_pass = m_ref <= m_buf;
         STU_F_GREATER:  o_pass = m_ref >  m_buf;
         STU_F_NOTEQUAL: o_pass = m_ref != m_buf;
         STU_F_GEQUAL:   o_pass = m_ref >= m_buf;
         default:        o_pass = 1'b1;
      endcase
      if (!o_pass) begin
         op = i_op_sfail;
      end else if (i_depth_pass) begin
         op = i_op_dppass;
      end else begin
         op = i_op_dpfail;
      end
      case (op)
         STU_OP_KEEP:    o_result = buf_l;
         STU_OP_ZERO:    o_result = '0;
         STU_OP_REPLACE: o_result = i_ref & lim;
         STU_OP_INCR:    o_result = (buf_l >= lim) ? lim : STU_PW'(buf_l + 1'b1);
         STU_OP_DECR:    o_result = (buf_l == '0) ? '0 : STU_PW'(buf_l - 1'b1);
         STU_OP_INVERT:  o_result = ~buf_l & lim;
         default:        o_result = buf_l;
      endcase
   end

endmodule

/* hw/stu_top.sv */
// Purpose: stencil test stage of the fragment pipeline with APB registers
// Assumes: fragments arrive one per cycle with no back-pressure
// Notes:   one register stage of latency; clock enable freezes everything
`timescale 1ns/100ps
module stu_top (
   // clock, reset, enable
   input  logic                   i_clk_sys,
   input  logic                   i_arst_n,
   input  logic                   i_ce,
   // register bus
   input  stu_pkg::stu_apb_req_t  i_apb,
   output stu_pkg::stu_apb_rsp_t  o_apb,
   // fragment stream
   input  stu_pkg::stu_frag_in_t  i_frag,
   output stu_pkg::stu_frag_out_t o_frag
);
   import stu_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [STU_DW-1:0] mode;
      logic [STU_DW-1:0] data;
      logic [STU_DW-1:0] host;
      logic [STU_DW-1:0] win;
      logic [STU_CW-1:0] pass_cnt;
      logic [STU_CW-1:0] kill_cnt;
      stu_apb_rsp_t      apb;
      stu_frag_out_t     frag;
   } stu_state_t;

   localparam stu_state_t STU_ST_RST = '{
      mode:     STU_MODE_RST,
      data:     STU_DATA_RST,
      host:     STU_HOST_RST,
      win:      STU_WIN_RST,
      pass_cnt: '0,
      kill_cnt: '0,
      apb:      '0,
      frag:     '0
   };

   stu_state_t st_r;
   stu_state_t st_nxt;

   // ----------------------------------------------------------------
   // decoded configuration
   // ----------------------------------------------------------------
   logic              cfg_en;
   logic              cfg_w4;
   stu_func_t         cfg_func;
   stu_op_t           cfg_dppass;
   stu_op_t           cfg_dpfail;
   stu_op_t           cfg_sfail;
   stu_src_t          cfg_src;
   logic [STU_PW-1:0] cfg_ref;
   logic [STU_PW-1:0] cfg_cmask;
   logic [STU_PW-1:0] cfg_wmask;
   logic [STU_PW-1:0] cfg_fcval;
   logic              cfg_force;
   logic              cfg_fcen;
   logic              cfg_depthen;

   assign cfg_en      = st_r.mode[STU_MODE_EN_POS];
   assign cfg_w4      = st_r.mode[STU_MODE_W4_POS];
   assign cfg_func    = stu_func_t'(st_r.mode[STU_MODE_FUNC_POS +: 3]);
   assign cfg_dppass  = stu_op_t'(st_r.mode[STU_MODE_DPPASS_POS +: 3]);
   assign cfg_dpfail  = stu_op_t'(st_r.mode[STU_MODE_DPFAIL_POS +: 3]);
   assign cfg_sfail   = stu_op_t'(st_r.mode[STU_MODE_SFAIL_POS +: 3]);
   assign cfg_src     = stu_src_t'(st_r.mode[STU_MODE_SRC_POS +: 2]);
   assign cfg_ref     = st_r.data[STU_DATA_REF_POS +: STU_PW];
   assign cfg_cmask   = st_r.data[STU_DATA_CMASK_POS +: STU_PW];
   assign cfg_wmask   = st_r.data[STU_DATA_WMASK_POS +: STU_PW];
   assign cfg_fcval   = st_r.data[STU_DATA_FCVAL_POS +: STU_PW];
   assign cfg_force   = st_r.win[STU_WIN_FORCE_POS];
   assign cfg_fcen    = st_r.win[STU_WIN_FCEN_POS];
   assign cfg_depthen = st_r.win[STU_WIN_DEPTHEN_POS];

   // ----------------------------------------------------------------
   // stencil arithmetic
   // ----------------------------------------------------------------
   logic [STU_PW-1:0] buf_val;
   logic              depth_ok;
   logic              test_pass;
   logic [STU_PW-1:0] test_result;

   // fast-cleared pixels have no valid stencil in memory yet
   assign buf_val  = (cfg_fcen && i_frag.fc_pixel) ? cfg_fcval : i_frag.dest_val;
   assign depth_ok = !cfg_depthen || i_frag.depth_pass;

   stu_plane_alu u_alu (
      .i_func       (cfg_func),
      .i_op_dppass  (cfg_dppass),
      .i_op_dpfail  (cfg_dpfail),
      .i_op_sfail   (cfg_sfail),
      .i_width4     (cfg_w4),
      .i_ref        (cfg_ref),
      .i_cmp_mask   (cfg_cmask),
      .i_buf        (buf_val),
      .i_depth_pass (depth_ok),
      .o_pass       (test_pass),
      .o_result     (test_result)
   );

   // ----------------------------------------------------------------
   // new value selection and plane masking
   // ----------------------------------------------------------------
   logic [STU_PW-1:0] src_val;
   logic [STU_PW-1:0] new_val;

   always_comb begin
      case (cfg_src)
         STU_SRC_TEST: src_val = test_result;
         STU_SRC_HOST: src_val = st_r.host[STU_PW-1:0];
         STU_SRC_COPY: src_val = i_frag.copy_val;
         STU_SRC_DEST: src_val = buf_val;
         default:      src_val = test_result;
      endcase
      new_val = (src_val & cfg_wmask) | (buf_val & ~cfg_wmask);
   end

   // ----------------------------------------------------------------
   // register access decode
   // ----------------------------------------------------------------
   logic              apb_setup;
   logic              apb_done;
   logic              addr_hit;
   logic [STU_DW-1:0] rd_word;

   assign apb_setup = i_apb.psel && !i_apb.penable;
   assign apb_done  = i_apb.psel && i_apb.penable && st_r.apb.pready;

   always_comb begin
      addr_hit = 1'b1;
      rd_word  = '0;
      case (i_apb.paddr)
         STU_OFF_MODE: rd_word = {{(STU_DW-STU_MODE_BITS){1'b0}}, st_r.mode[STU_MODE_BITS-1:0]};
         STU_OFF_DATA: rd_word = st_r.data;
         STU_OFF_HOST: rd_word = st_r.host;
         STU_OFF_WIN:  rd_word = {{(STU_DW-STU_WIN_BITS){1'b0}}, st_r.win[STU_WIN_BITS-1:0]};
         STU_OFF_STAT: rd_word = {st_r.kill_cnt, st_r.pass_cnt};
         default:      addr_hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // fragment outcome
   // ----------------------------------------------------------------
   logic tested;
   logic keep_frag;
   logic write_plane;

   // a fragment already rejected upstream is carried along but never tested
   assign tested      = i_frag.valid && i_frag.prior_ok && cfg_en && !cfg_force;
   assign keep_frag   = i_frag.prior_ok && (cfg_force || !cfg_en || test_pass);
   assign write_plane = i_frag.valid && (cfg_force || (cfg_en && i_frag.prior_ok));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;

      // bus answer: ready in the first access cycle, zero wait states
      st_nxt.apb.pready = apb_setup;
      if (apb_setup) begin
         st_nxt.apb.pslverr = !addr_hit;
         st_nxt.apb.prdata  = (addr_hit && !i_apb.pwrite) ? rd_word : '0;
      end else if (apb_done) begin
         st_nxt.apb.pslverr = 1'b0;
         st_nxt.apb.prdata  = '0;
      end

      // fragment result, one cycle behind the input
      st_nxt.frag.valid        = i_frag.valid;
      st_nxt.frag.alive        = i_frag.valid && keep_frag;
      st_nxt.frag.plane_we     = write_plane;
      st_nxt.frag.force_update = i_frag.valid && cfg_force;
      st_nxt.frag.plane_val    = new_val;

      // outcome counters saturate rather than wrap so software sees overflow
      if (tested && test_pass && st_r.pass_cnt != '1) begin
         st_nxt.pass_cnt = STU_CW'(st_r.pass_cnt + 1'b1);
      end
      if (tested && !test_pass && st_r.kill_cnt != '1) begin
         st_nxt.kill_cnt = STU_CW'(st_r.kill_cnt + 1'b1);
      end

      // register writes; a status write clears counters but a same-cycle
      // event still counts, so it is never lost
      if (apb_done && i_apb.pwrite && addr_hit) begin
         case (i_apb.paddr)
            STU_OFF_MODE: st_nxt.mode = {{(STU_DW-STU_MODE_BITS){1'b0}}, i_apb.pwdata[STU_MODE_BITS-1:0]};
            STU_OFF_DATA: st_nxt.data = i_apb.pwdata;
            STU_OFF_HOST: st_nxt.host = i_apb.pwdata;
            STU_OFF_WIN:  st_nxt.win  = {{(STU_DW-STU_WIN_BITS){1'b0}}, i_apb.pwdata[STU_WIN_BITS-1:0]};
            STU_OFF_STAT: begin
               st_nxt.pass_cnt = STU_CW'(tested && test_pass);
               st_nxt.kill_cnt = STU_CW'(tested && !test_pass);
            end
            default: st_nxt = st_nxt;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r <= STU_ST_RST;
      end else if (i_ce) begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_apb  = st_r.apb;
   assign o_frag = st_r.frag;

endmodule

/* verification/stu_frag_src.sv */
// Purpose: upstream fragment stage model feeding the stencil unit
// Assumes: one fragment per load pulse, no back-pressure
// Notes:   idle cycles scramble the data so a stale value never looks fresh
`timescale 1ns/100ps
module stu_frag_src (
   // clock and reset
   input  logic                  i_clk_sys,
   input  logic                  i_arst_n,
   // bench side
   input  logic                  i_load,
   input  stu_pkg::stu_frag_in_t i_frag,
   // unit side
   output stu_pkg::stu_frag_in_t o_frag
);
   import stu_pkg::*;
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_frag <= '0;
      end else if (i_load) begin
         o_frag <= i_frag;
      end else begin
         o_frag.valid    <= 1'b0;
         o_frag.dest_val <= ~o_frag.dest_val;
         o_frag.copy_val <= ~o_frag.copy_val;
      end
   end
endmodule

/* verification/stu_top_props.sv */
// Purpose: port-level checks of the stencil unit
// Assumes: single clock domain, asynchronous active-low reset
// Notes:   register contents are invisible here, so checks tie outputs to inputs
`timescale 1ns/100ps
module stu_top_props (
   input logic                   i_clk_sys,
   input logic                   i_arst_n,
   input logic                   i_ce,
   input stu_pkg::stu_apb_req_t  i_apb,
   input stu_pkg::stu_apb_rsp_t  o_apb,
   input stu_pkg::stu_frag_in_t  i_frag,
   input stu_pkg::stu_frag_out_t o_frag
);
   import stu_pkg::*;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   ready_after_setup_a: assert property (
      i_ce && i_apb.psel && !i_apb.penable |=> o_apb.pready) else $error("no answer after setup");
   // a frozen unit holds its answer, so both checks below only look across enabled edges
   ready_one_cycle_a: assert property (
      i_ce && o_apb.pready |=> !o_apb.pready) else $error("pready held too long");
   idle_no_ready_a: assert property (
      i_ce && !i_apb.psel |=> !o_apb.pready) else $error("answer without request");
   err_with_ready_a: assert property (
      o_apb.pslverr |-> o_apb.pready) else $error("error outside answer");
   rdata_idle_zero_a: assert property (
      !o_apb.pready |-> o_apb.prdata == '0) else $error("read data not cleared");
   valid_follows_a: assert property (
      i_ce |=> o_frag.valid == $past(i_frag.valid)) else $error("fragment lost or invented");
   prior_fail_drop_a: assert property (
      i_ce && i_frag.valid && !i_frag.prior_ok |=> !o_frag.alive && o_frag.plane_we == o_frag.force_update)
      else $error("untested fragment kept or written");
   force_writes_a: assert property (
      o_frag.valid && o_frag.force_update |-> o_frag.plane_we) else $error("forced write missing");
   write_needs_valid_a: assert property (
      o_frag.plane_we |-> o_frag.valid) else $error("write without fragment");
endmodule

bind stu_top stu_top_props u_stu_top_props (
   .i_clk_sys(i_clk_sys),
   .i_arst_n (i_arst_n),
   .i_ce     (i_ce),
   .i_apb    (i_apb),
   .o_apb    (o_apb),
   .i_frag   (i_frag),
   .o_frag   (o_frag)
);

/* verification/test_stu_top.sv */
// Purpose: self-checking bench of the stencil unit
// Assumes: APB answers on its own pace, one fragment in flight at a time
// Notes:   clock enable is dropped once to show a frozen unit; a mid-run reset closes the run
`timescale 1ns/100ps
module test_stu_top;
   import stu_pkg::*;
   typedef struct packed {
      logic [31:0]   mode, data;
      logic [2:0]    win;
      logic [31:0]   host;
      stu_frag_in_t  fin;
      stu_frag_out_t fex;
   } stu_row_t;
   logic          clk_sys;
   logic          arst_n;
   logic          ce;
   logic          ld;
   stu_apb_req_t  apb_q;
   stu_apb_rsp_t  apb_r;
   stu_frag_in_t  fin_q;
   stu_frag_in_t  frag_in;
   stu_frag_out_t frag_out;
   stu_row_t      rows [15];
   int            fail_count;
   int            samples_checked;

   stu_top u_stu_top (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_ce(ce), .i_apb(apb_q),
                      .o_apb(apb_r), .i_frag(frag_in), .o_frag(frag_out));
   stu_frag_src u_stu_frag_src (.i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_load(ld),
                                .i_frag(fin_q), .o_frag(frag_in));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] m(input int en, dp, df, sf, fn, sr, w4);
      m = {16'h0000, 1'(w4), 2'(sr), 3'(fn), 3'(sf), 3'(df), 3'(dp), 1'(en)};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clk_sys);
      apb_q.psel    <= 1'b1;
      apb_q.penable <= 1'b0;
      apb_q.pwrite  <= wr;
      apb_q.paddr   <= a;
      apb_q.pwdata  <= d;
      @(posedge clk_sys);
      apb_q.penable <= 1'b1;
      // no cycle count assumed: only the watchdog ends a wait for the answer
      do begin
         @(posedge clk_sys);
      end while (apb_r.pready !== 1'b1);
      rd = apb_r.prdata;
      er = apb_r.pslverr;
      apb_q.psel    <= 1'b0;
      apb_q.penable <= 1'b0;
      apb_q.pwdata  <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, '0, rd, er);
      chk("prdata", rd, exp);
      chk("pslverr", {31'h0, er}, {31'h0, eexp});
   endtask
   task automatic cfg(input logic [31:0] md, dt, input logic [2:0] wn, input logic [31:0] hs);
      wr(STU_OFF_MODE, md);
      wr(STU_OFF_DATA, dt);
      wr(STU_OFF_WIN, {29'h0, wn});
      wr(STU_OFF_HOST, hs);
   endtask
   // the fragment is presented one cycle after loading and taken on the next edge
   task automatic send(input stu_frag_in_t f, input stu_frag_out_t e);
      @(posedge clk_sys);
      ld    <= 1'b1;
      fin_q <= f;
      @(posedge clk_sys);
      ld <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("frag_out", {20'h0_0000, frag_out}, {20'h0_0000, e});
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      #120000;
      fail_count++;
      wrap_up();
   end
   initial begin
      logic [7:0] rv;
      logic [7:0] pat;
      arst_n = 1'b0;
      ce = 1'b1;
      ld = 1'b0;
      apb_q = '0;
      fin_q = '0;
      fail_count = 0;
      samples_checked = 0;
      rows[0]  = '{m(1, 3, 0, 0, 7, 0, 0), STU_DATA_RST, 3'd0, '0, 20'hC_FF3C, 12'hEFF};
      rows[1]  = '{m(1, 3, 0, 0, 7, 0, 1), 32'h00FF_0F00, 3'd0, '0, 20'hC_0F3C, 12'hE0F};
      rows[2]  = '{m(1, 4, 0, 0, 7, 0, 0), STU_DATA_RST, 3'd0, '0, 20'hC_003C, 12'hE00};
      rows[3]  = '{m(1, 5, 0, 0, 7, 0, 0), STU_DATA_RST, 3'd0, '0, 20'hC_073C, 12'hEF8};
      rows[4]  = '{m(1, 1, 5, 0, 7, 0, 0), STU_DATA_RST, 3'd0, '0, 20'hC_073C, 12'hE00};
      rows[5]  = '{m(1, 1, 5, 0, 7, 0, 0), STU_DATA_RST, 3'd4, '0, 20'hC_073C, 12'hEF8};
      rows[6]  = '{m(1, 1, 5, 0, 7, 0, 0), STU_DATA_RST, 3'd4, '0, 20'hE_073C, 12'hE00};
      rows[7]  = '{m(1, 0, 0, 1, 2, 0, 0), 32'h00FF_0F15, 3'd0, '0, 20'hC_253C, 12'hE25};
      rows[8]  = '{m(1, 0, 0, 0, 7, 1, 0), 32'h00F0_FF00, 3'd0, 32'hFFFF_FF5A, 20'hC_073C, 12'hE57};
      rows[9]  = '{m(1, 0, 0, 0, 7, 2, 0), STU_DATA_RST, 3'd0, '0, 20'hC_073C, 12'hE3C};
      rows[10] = '{m(1, 0, 0, 0, 7, 3, 0), 32'hA5FF_FF00, 3'd2, '0, 20'hD_073C, 12'hEA5};
      rows[11] = '{m(1, 0, 0, 0, 7, 3, 0), 32'hA5FF_FF00, 3'd2, '0, 20'hC_073C, 12'hE07};
      rows[12] = '{m(0, 0, 0, 0, 0, 0, 0), STU_DATA_RST, 3'd0, '0, 20'hC_073C, 12'hC07};
      rows[13] = '{m(0, 0, 0, 0, 0, 0, 0), STU_DATA_RST, 3'd1, '0, 20'h8_073C, 12'hB07};
      rows[14] = '{m(1, 0, 0, 0, 7, 0, 0), STU_DATA_RST, 3'd0, '0, 20'h8_073C, 12'h807};
      repeat (20) @(posedge clk_sys);
      arst_n <= 1'b1;
      rdc(STU_OFF_MODE, STU_MODE_RST, 1'b0);
      rdc(STU_OFF_DATA, STU_DATA_RST, 1'b0);
      rdc(STU_OFF_HOST, STU_HOST_RST, 1'b0);
      rdc(STU_OFF_WIN, STU_WIN_RST, 1'b0);
      rdc(STU_OFF_STAT, 32'h0000_0000, 1'b0);
      $display("reset values done");
      wr(STU_OFF_HOST, 32'h1234_5678);
      rdc(STU_OFF_HOST, 32'h1234_5678, 1'b0);
      wr(STU_OFF_MODE, 32'hFFFF_FFFF);
      rdc(STU_OFF_MODE, 32'h0000_FFFF, 1'b0);
      wr(8'h14, 32'hFFFF_FFFF);
      rdc(8'h14, 32'h0000_0000, 1'b1);
      $display("register access done");
      foreach (rows[i]) begin
         cfg(rows[i].mode, rows[i].data, rows[i].win, rows[i].host);
         send(rows[i].fin, rows[i].fex);
      end
      $display("table rows done");
      wr(STU_OFF_STAT, 32'h0000_0000);
      for (int r = 0; r < 3; r++) begin
         rv = 8'h05 + 8'(r);
         pat = (r == 0) ? 8'hAA : ((r == 1) ? 8'hCC : 8'hF0);
         for (int fn = 0; fn < 8; fn++) begin
            cfg(m(1, 2, 0, 1, fn, 0, 0), {16'h00FF, 8'hFF, rv}, 3'd0, '0);
            send(20'hC_063C, {2'b11 & {1'b1, pat[fn]}, 2'b10, pat[fn] ? rv : 8'h00});
         end
      end
      rdc(STU_OFF_STAT, 32'h000C_000C, 1'b0);
      $display("compare sweep done");
      // frozen unit must ignore a fragment held at its input, then take it once enabled
      cfg(m(1, 0, 0, 0, 7, 2, 0), STU_DATA_RST, 3'd0, '0);
      @(posedge clk_sys);
      ce    <= 1'b0;
      ld    <= 1'b1;
      fin_q <= 20'hC_073C;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("frozen valid", {31'h0000_0000, frag_out.valid}, 32'h0000_0000);
      @(posedge clk_sys);
      ce <= 1'b1;
      ld <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("thawed frag", {20'h0_0000, frag_out}, 32'h0000_0E3C);
      $display("clock enable done");
      // second reset in mid-run: outputs clear at once, registers return to reset values
      @(posedge clk_sys);
      arst_n <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("reset frag", {20'h0_0000, frag_out}, 32'h0000_0000);
      @(posedge clk_sys);
      arst_n <= 1'b1;
      rdc(STU_OFF_MODE, STU_MODE_RST, 1'b0);
      rdc(STU_OFF_DATA, STU_DATA_RST, 1'b0);
      rdc(STU_OFF_STAT, 32'h0000_0000, 1'b0);
      $display("mid-run reset done");
      wrap_up();
   end
endmodule
